// [design/lpmc_core.sv]
// low power mode controller: wait and stop sequencing with apb config
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "lpmc_params.svh"
module lpmc_core
    import lpmc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_instr,
    input  wire logic        stop_instr,
    input  wire logic        xtal_tick,
    input  wire logic        mem_busy,
    input  wire lpmc_wake_t  wake_in,
    output lpmc_gate_t       gate_out,
    output logic             irq_mask_clr,
    output logic             irq_mask_set,
    output logic             sys_reset_req,
    output logic             mem_abort
);

    // ************************************************************
    // apb slave
    // ************************************************************
    logic [5:0]  cfg_r;
    logic [5:0]  cfg_nxt;
    lpmc_state_t state_r;
    lpmc_state_t state_nxt;
    logic [11:0] rec_cnt_r;
    logic        last_exit_rst_r;
    logic        wr_en;
    logic        rd_en;
    logic        cmd_wait;
    logic        cmd_stop;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;                       // zero wait states
    assign pslverr = psel && penable &&
                     !(hit(paddr, `LPMC_CFG_OFS) || hit(paddr, `LPMC_STAT_OFS) || hit(paddr, `LPMC_CMD_OFS));

    // config write
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_en && hit(paddr, `LPMC_CFG_OFS)) begin
            cfg_nxt = pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= 6'h00;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // software may also request modes through the command register
    assign cmd_wait = wait_instr || (wr_en && hit(paddr, `LPMC_CMD_OFS) && pwdata[`LPMC_CMD_WAIT]);
    assign cmd_stop = stop_instr || (wr_en && hit(paddr, `LPMC_CMD_OFS) && pwdata[`LPMC_CMD_STOP]);

    // read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hit(paddr, `LPMC_CFG_OFS)) begin
                prdata <= {26'h0000000, cfg_r};
            end else if (hit(paddr, `LPMC_STAT_OFS)) begin
                prdata <= {15'h0000, rec_cnt_r, last_exit_rst_r, 1'b0, state_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // mode state machine
    // ************************************************************
    logic stop_ok;
    logic wake_wait;
    logic wake_stop_irq;
    logic monitor_rst;
    logic rec_done;

    // RULE_15 stop permit
    assign stop_ok = cfg_r[`LPMC_CFG_STOP_EN];

    // RULE_18 monitor reset
    assign monitor_rst = cfg_r[`LPMC_CFG_LVI_EN] && cfg_r[`LPMC_CFG_LVI_RST] && wake_in.monitor_trip;

    // RULE_09 RULE_19 wait wakes
    assign wake_wait = (wake_in.ext_irq && !wake_in.ext_irq_mask) ||
                       (wake_in.keypad_irq && !wake_in.keypad_irq_mask) ||
                       wake_in.conv_irq || wake_in.serial_irq || wake_in.loop_irq ||
                       (wake_in.break_irq && cfg_r[`LPMC_CFG_BRK_EN]);

    // RULE_16 RULE_17 stop wakes
    assign wake_stop_irq = (wake_in.ext_irq && !wake_in.ext_irq_mask) ||
                           (wake_in.keypad_irq && !wake_in.keypad_irq_mask) ||
                           (wake_in.break_irq && cfg_r[`LPMC_CFG_BRK_EN]);

    assign rec_done = (rec_cnt_r == 12'h000) && xtal_tick;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            LPMC_RUN: begin
                if (cmd_stop && stop_ok) begin
                    state_nxt = LPMC_STOP;
                end else if (cmd_wait) begin
                    state_nxt = LPMC_WAIT;
                end
            end
            LPMC_WAIT: begin
                if (wake_wait || monitor_rst) begin
                    state_nxt = LPMC_RUN;
                end
            end
            LPMC_STOP: begin
                if (wake_stop_irq || monitor_rst) begin
                    state_nxt = LPMC_RECOVER;
                end
            end
            LPMC_RECOVER: begin
                if (rec_done) begin
                    state_nxt = LPMC_RUN;
                end
            end
            default: state_nxt = LPMC_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= LPMC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // stop recovery counter
    // ************************************************************
    // RULE_21 recovery count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_cnt_r <= 12'h000;
        end else if (state_r == LPMC_STOP && state_nxt == LPMC_RECOVER) begin
            rec_cnt_r <= cfg_r[`LPMC_CFG_SHORT_RECOVERY_SEL] ? `LPMC_REC_SHORT : `LPMC_REC_LONG;
        end else if (state_r == LPMC_RECOVER && xtal_tick && rec_cnt_r != 12'h000) begin
            rec_cnt_r <= rec_cnt_r - 12'h001;
        end
    end

    // remember how the last low power exit happened
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_exit_rst_r <= 1'b0;
        end else if ((state_r == LPMC_WAIT || state_r == LPMC_STOP) && monitor_rst) begin
            last_exit_rst_r <= 1'b1;
        end else if ((state_r == LPMC_WAIT && wake_wait) || (state_r == LPMC_STOP && wake_stop_irq)) begin
            last_exit_rst_r <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic in_stop;
    logic osc_run;
    assign in_stop = (state_r == LPMC_STOP) || (state_r == LPMC_RECOVER);
    assign osc_run = cfg_r[`LPMC_CFG_OSC_RUN];

    // gating registered so glitches never reach the clock tree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_out <= '0;
        end else begin
            // RULE_01 RULE_02 RULE_05 cpu clock
            gate_out.cpu_clk_en     <= (state_nxt == LPMC_RUN);
            // RULE_02 bus clock in stop
            gate_out.bus_clk_en     <= !(state_nxt == LPMC_STOP || state_nxt == LPMC_RECOVER) || osc_run;
            // RULE_06 RULE_07 RULE_08 generator gating
            gate_out.osc_en         <= !(state_nxt == LPMC_STOP) || osc_run;
            gate_out.loop_en        <= !(state_nxt == LPMC_STOP);
            gate_out.gen_outs_en    <= !(state_nxt == LPMC_STOP) || osc_run;
            // RULE_14 watchdog in stop
            gate_out.wdog_clk_en    <= !(state_nxt == LPMC_STOP);
            gate_out.wdog_presc_clr <= (state_r != LPMC_STOP) && (state_nxt == LPMC_STOP);
            // RULE_11 converter abort
            gate_out.conv_abort     <= (state_r != LPMC_STOP) && (state_nxt == LPMC_STOP);
            gate_out.conv_active    <= !(state_nxt == LPMC_STOP || state_nxt == LPMC_RECOVER);
            // RULE_13 RULE_22 break unit held, registers kept
            gate_out.break_active   <= cfg_r[`LPMC_CFG_BRK_EN] && !(state_nxt == LPMC_STOP);
            gate_out.monitor_active <= cfg_r[`LPMC_CFG_LVI_EN];
            gate_out.serial_active  <= !(state_nxt == LPMC_STOP || state_nxt == LPMC_RECOVER);
            // RULE_20 memory standby
            gate_out.mem_standby    <= (state_nxt == LPMC_WAIT) || (state_nxt == LPMC_STOP);
        end
    end

    // RULE_03 RULE_04 interrupt mask handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_clr  <= 1'b0;
            irq_mask_set  <= 1'b0;
            sys_reset_req <= 1'b0;
            mem_abort     <= 1'b0;
        end else begin
            irq_mask_clr  <= (state_r == LPMC_RUN) && (state_nxt == LPMC_WAIT || state_nxt == LPMC_STOP);
            irq_mask_set  <= (state_r == LPMC_WAIT || state_r == LPMC_STOP) && monitor_rst;
            sys_reset_req <= monitor_rst;
            // RULE_20 abort in flight program or erase
            mem_abort     <= (state_r == LPMC_RUN) && (state_nxt != LPMC_RUN) && mem_busy;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************

    // cpu clock may only come back on the edge that leaves recovery
    a_stop_cpu_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        in_stop |-> !gate_out.cpu_clk_en || $past(state_r) == LPMC_RECOVER) else $error("cpu clock in stop");

    a_wait_cpu_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        state_r == LPMC_WAIT |-> !gate_out.cpu_clk_en && gate_out.bus_clk_en) else $error("wait gating wrong");
    a_stop_bus_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        state_r == LPMC_STOP && !osc_run && $stable(cfg_r) |-> !gate_out.bus_clk_en) else $error("bus clock in stop");
    a_mask_clr_entry: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        state_r == LPMC_RUN && state_nxt == LPMC_WAIT |=> irq_mask_clr) else $error("mask not cleared");
    a_mask_set_rst: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        state_r == LPMC_STOP && monitor_rst |=> irq_mask_set && sys_reset_req) else $error("mask not set");
    a_recover_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        state_r == LPMC_RECOVER && !rec_done |=> !gate_out.cpu_clk_en) else $error("cpu ran in recovery");
    a_stop_gen_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        state_r == LPMC_STOP && !osc_run && $past(state_r) == LPMC_STOP && $stable(cfg_r)
        |-> !gate_out.osc_en && !gate_out.gen_outs_en) else $error("generator on");
    a_stop_only_loop: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        state_r == LPMC_STOP && $past(state_r) == LPMC_STOP && $past(osc_run)
        |-> gate_out.osc_en && !gate_out.loop_en) else $error("osc off");
    a_stop_permit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
        state_r == LPMC_RUN && !stop_ok |=> state_r != LPMC_STOP) else $error("stop not permitted");
    a_rec_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
        state_r == LPMC_STOP && state_nxt == LPMC_RECOVER && cfg_r[`LPMC_CFG_SHORT_RECOVERY_SEL] |=> rec_cnt_r == 12'h01f)
        else $error("short recovery load wrong");
    a_mem_abort: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        state_r == LPMC_RUN && state_nxt == LPMC_WAIT && mem_busy |=> mem_abort && gate_out.mem_standby)
        else $error("memory not aborted");

    // one-cycle pulses at stop entry toward converter and watchdog
    a_stop_pulses: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        state_r == LPMC_RUN && state_nxt == LPMC_STOP |=> gate_out.conv_abort && gate_out.wdog_presc_clr)
        else $error("stop entry pulses missing");

    // generator, loop and converter stay alive through wait
    a_wait_gen_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        state_r == LPMC_WAIT |-> gate_out.osc_en && gate_out.loop_en && gate_out.conv_active)
        else $error("generator off in wait");

    // any wait wake returns to run with the cpu clock on
    a_wait_wake_run: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        state_r == LPMC_WAIT && wake_wait |=> state_r == LPMC_RUN && gate_out.cpu_clk_en)
        else $error("wait wake ignored");

    // unmasked pin or keypad request leaves stop into recovery
    a_stop_irq_wake: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
        state_r == LPMC_STOP && wake_stop_irq |=> state_r == LPMC_RECOVER)
        else $error("stop wake ignored");

    // break and serial units idle while stopped
    a_stop_units_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        state_r == LPMC_STOP |-> !gate_out.break_active && !gate_out.serial_active)
        else $error("unit active in stop");

    // monitor reset ends wait and sets the mask
    a_monitor_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        state_r == LPMC_WAIT && monitor_rst |=> state_r == LPMC_RUN && irq_mask_set)
        else $error("monitor reset ignored");

    // stop entry clears the interrupt mask as wait does
    a_mask_clr_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        state_r == LPMC_RUN && state_nxt == LPMC_STOP |=> irq_mask_clr)
        else $error("mask not cleared on stop");

    // full recovery length when the short option is off
    a_rec_long: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
        state_r == LPMC_STOP && state_nxt == LPMC_RECOVER && !cfg_r[`LPMC_CFG_SHORT_RECOVERY_SEL] |=> rec_cnt_r == 12'hfff)
        else $error("long recovery load wrong");

    // ************************************************************
    // coverage
    // ************************************************************


    c_wait_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == LPMC_WAIT ##1 state_r == LPMC_RUN);
    c_stop_recover: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == LPMC_RECOVER ##1 state_r == LPMC_RUN);
    c_monitor_exit: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == LPMC_WAIT && monitor_rst);

    c_abort_prog: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == LPMC_RUN && state_nxt == LPMC_WAIT && mem_busy);


endmodule : lpmc_core

// [pkg/lpmc_params.svh]
// constants for the low power mode controller
// What this block does
// RULE_01 - wait stops cpu clock, bus clock keeps running
// RULE_02 - stop stops cpu clock; bus clock too unless oscillator runs in stop
// RULE_03 - wait clears interrupt mask; reset exit sets it, interrupt exit keeps clear
// RULE_04 - stop clears interrupt mask; reset exit sets it, external irq exit keeps clear
// RULE_05 - cpu clock stays off until stabilization delay after stop exit
// RULE_06 - stop without oscillator run gates oscillator, loop and forces generator outputs low
// RULE_07 - stop with oscillator run shuts only the loop off
// RULE_08 - clock generator stays active in wait; software may switch the loop off first
// RULE_09 - converter keeps running in wait; its enabled request wakes wait
// RULE_10 - software powers converter down via channel select when not needed as wake source
// RULE_11 - stop aborts converter conversion; it resumes after external interrupt exit
// RULE_12 - software waits one conversion period after stop before using converter result
// RULE_13 - break unit active in wait when enabled; inactive in stop, registers kept
// RULE_14 - watchdog counts in wait; stop removes its crystal clock and clears prescaler
// RULE_15 - configuration bit permits stop; cleared, stop instruction is ignored
// RULE_16 - external irq unit active in both modes; unmasked request wakes either
// RULE_17 - keypad unit active in both modes; unmasked request wakes either
// RULE_18 - enabled supply monitor active in both; with reset enabled, its reset ends either
// RULE_19 - serial unit active in wait; its enabled request ends wait
// RULE_20 - wait or stop during memory program or erase aborts it into standby
// RULE_21 - stop exit holds clocks 4096 crystal cycles, 32 with short recovery
// RULE_22 - peripheral registers kept across wait and stop, changed only on reset exit
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

// ************************************************************
// register map
// ************************************************************
`define LPMC_CFG_OFS        12'h000
`define LPMC_STAT_OFS       12'h004
`define LPMC_CMD_OFS        12'h008
`define LPMC_CFG_RESET      32'h0000_0000

// config field positions
`define LPMC_CFG_STOP_EN    0
`define LPMC_CFG_OSC_RUN    1
`define LPMC_CFG_SHORT_RECOVERY_SEL      2
`define LPMC_CFG_LVI_EN     3
`define LPMC_CFG_LVI_RST    4
`define LPMC_CFG_BRK_EN     5

// command field positions
`define LPMC_CMD_WAIT       0
`define LPMC_CMD_STOP       1

// ************************************************************
// timing
// ************************************************************
`define LPMC_REC_LONG       12'hfff
`define LPMC_REC_SHORT      12'h01f

`endif

// [pkg/lpmc_pkg.sv]
// types for the low power mode controller
package lpmc_pkg;

    typedef enum logic [2:0] {
        LPMC_RUN     = 3'b000,
        LPMC_WAIT    = 3'b001,
        LPMC_STOP    = 3'b010,
        LPMC_RECOVER = 3'b011
    } lpmc_state_t;

    // wake sources from peripherals
    typedef struct packed {
        logic ext_irq;
        logic ext_irq_mask;
        logic keypad_irq;
        logic keypad_irq_mask;
        logic conv_irq;
        logic serial_irq;
        logic break_irq;
        logic loop_irq;
        logic monitor_trip;
    } lpmc_wake_t;

    // gating and control toward the clock tree and peripherals
    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic osc_en;
        logic loop_en;
        logic gen_outs_en;
        logic wdog_clk_en;
        logic wdog_presc_clr;
        logic conv_abort;
        logic conv_active;
        logic break_active;
        logic monitor_active;
        logic serial_active;
        logic mem_standby;
    } lpmc_gate_t;

endpackage : lpmc_pkg

// [test/low_power_mode_control_tb.sv]
// testbench for the low power mode controller
`timescale 1ns/10ps
module low_power_mode_control_tb;
    import lpmc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic wait_instr, stop_instr, xtal_tick, mem_busy, irq_mask_clr, irq_mask_set, e;
    logic ibit, abort_seen, presc_seen, mem_abort, sys_reset_req, rst_seen;
    logic [15:0] ticks, t0;
    lpmc_wake_t wake_in, idle;
    lpmc_gate_t gate_out;
    int num_errors, comparisons, i;

    lpmc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_instr(wait_instr), .stop_instr(stop_instr), .xtal_tick(xtal_tick), .mem_busy(mem_busy),
        .wake_in(wake_in), .gate_out(gate_out), .irq_mask_clr(irq_mask_clr),
        .irq_mask_set(irq_mask_set), .sys_reset_req(sys_reset_req), .mem_abort(mem_abort));
    // sticky capture of the reset request, which stays high while the monitor reset holds
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) rst_seen <= 1'b0;
        else if (sys_reset_req) rst_seen <= 1'b1;
    end
    lpmc_partner far (.pclk(pclk), .presetn(presetn), .irq_mask_clr(irq_mask_clr),
        .irq_mask_set(irq_mask_set), .mem_abort(mem_abort), .gate_out(gate_out),
        .xtal_tick(xtal_tick), .ibit(ibit), .abort_seen(abort_seen), .presc_seen(presc_seen),
        .ticks(ticks));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // apb cycle held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task instr(input logic s);
        @(posedge pclk);
        if (s) stop_instr <= 1'b1;
        else wait_instr <= 1'b1;
        @(posedge pclk);
        stop_instr <= 1'b0;
        wait_instr <= 1'b0;
    endtask : instr
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    task upto(input logic [15:0] n);
        while (ticks !== n) @(posedge pclk);
        #1;
    endtask : upto
    task finish_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // clock and watchdog, the long recovery needs about 16k cycles
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        finish_test;
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        idle = '0;
        idle.ext_irq_mask = 1'b1;
        idle.keypad_irq_mask = 1'b1;
        {psel, penable, pwrite, wait_instr, stop_instr, mem_busy} = '0;
        paddr = '0;
        pwdata = '0;
        wake_in = idle;
        num_errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wt(2);
        apb(1'b0, 12'h000, 0); chk(r, 32'h0);
        apb(1'b0, 12'h0fc, 0); chk({e, r[30:0]}, 32'h8000_0000);
        // wait entered during memory programming
        @(posedge pclk) mem_busy <= 1'b1;
        instr(1'b0);
        wt(3);
        chk({gate_out.cpu_clk_en, gate_out.bus_clk_en, ibit}, 3'b010);
        chk({abort_seen, gate_out.mem_standby, gate_out.wdog_clk_en}, 3'b111);
        chk({gate_out.conv_active, gate_out.gen_outs_en, gate_out.serial_active}, 3'b111);
        apb(1'b0, 12'h004, 0); chk(r[2:0], 3'h1);
        @(posedge pclk) mem_busy <= 1'b0;
        // channel select left on, converter kept as a wake source
        wake_in.conv_irq <= 1'b1;
        wt(3); chk(gate_out.cpu_clk_en, 1'b1);
        @(posedge pclk) wake_in <= idle;
        // stop refused while not permitted
        instr(1'b1);
        wt(3); chk(gate_out.cpu_clk_en, 1'b1);
        // stop, oscillator off, short recovery, masked then unmasked pin
        apb(1'b1, 12'h000, 32'h5);
        instr(1'b1);
        wt(3);
        chk({gate_out.cpu_clk_en, gate_out.bus_clk_en, gate_out.osc_en, gate_out.loop_en}, 4'h0);
        chk({gate_out.gen_outs_en, gate_out.wdog_clk_en, gate_out.conv_active, presc_seen}, 4'h1);
        chk({gate_out.break_active, ibit}, 2'b00);
        @(posedge pclk) wake_in.ext_irq <= 1'b1;
        wt(10); chk(gate_out.cpu_clk_en, 1'b0);
        @(posedge pclk) wake_in.ext_irq_mask <= 1'b0;
        t0 = ticks;
        @(posedge pclk) wake_in <= idle;
        upto(t0 + 16'd28); chk(gate_out.cpu_clk_en, 1'b0);
        upto(t0 + 16'd36); chk({gate_out.cpu_clk_en, ibit}, 2'b10);
        // converter result not used right after stop, no settle check needed
        // stop with oscillator kept, full recovery, keypad wake
        apb(1'b1, 12'h000, 32'h23);
        instr(1'b1);
        wt(3); chk({gate_out.bus_clk_en, gate_out.osc_en, gate_out.loop_en}, 3'b110);
        apb(1'b0, 12'h000, 0); chk(r, 32'h23);
        @(posedge pclk) wake_in.keypad_irq <= 1'b1;
        wake_in.keypad_irq_mask <= 1'b0;
        t0 = ticks;
        @(posedge pclk) wake_in <= idle;
        upto(t0 + 16'd4000); chk(gate_out.cpu_clk_en, 1'b0);
        upto(t0 + 16'd4104); chk(gate_out.cpu_clk_en, 1'b1);
        // each wait wake source except the converter in turn, break enabled
        for (i = 0; i < 5; i++) begin
            instr(1'b0);
            wt(3); chk({gate_out.cpu_clk_en, gate_out.break_active}, 2'b01);
            @(posedge pclk);
            wake_in.ext_irq <= 1'b1;
            wake_in.keypad_irq <= 1'b1;
            wt(3); chk(gate_out.cpu_clk_en, 1'b0);
            @(posedge pclk);
            case (i)
                0: wake_in.serial_irq <= 1'b1;
                1: wake_in.loop_irq <= 1'b1;
                2: wake_in.break_irq <= 1'b1;
                3: wake_in.ext_irq_mask <= 1'b0;
                default: wake_in.keypad_irq_mask <= 1'b0;
            endcase
            wt(3); chk(gate_out.cpu_clk_en, 1'b1);
            @(posedge pclk) wake_in <= idle;
        end
        // supply monitor reset ends wait and sets the mask
        apb(1'b1, 12'h000, 32'h18);
        instr(1'b0);
        wt(3); chk({gate_out.monitor_active, ibit}, 2'b10);
        @(posedge pclk) wake_in.monitor_trip <= 1'b1;
        wt(3); chk({gate_out.cpu_clk_en, ibit}, 2'b11);
        @(posedge pclk) wake_in <= idle;
        apb(1'b0, 12'h004, 0); chk({r[4], r[2:0], rst_seen}, 5'h11);
        wt(2);
        finish_test;
    end
endmodule : low_power_mode_control_tb

// [test/lpmc_partner.sv]
// partner model: cpu mask bit, crystal tick source and event capture
`timescale 1ns/10ps
module lpmc_partner
    import lpmc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        irq_mask_clr,
    input  wire logic        irq_mask_set,
    input  wire logic        mem_abort,
    input  wire lpmc_gate_t  gate_out,
    output logic             xtal_tick,
    output logic             ibit,
    output logic             abort_seen,
    output logic             presc_seen,
    output logic      [15:0] ticks
);
    logic [1:0] div_r;
    // crystal tick at a quarter of the bus rate, a one-cycle pulse in every four pclk cycles, locked to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
            ticks <= 16'h0000;
        end else begin
            div_r <= div_r + 2'h1;
            ticks <= ticks + {15'h0000, xtal_tick};
        end
    end
    assign xtal_tick = (div_r == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ibit <= 1'b1;
        end else if (irq_mask_set) begin
            ibit <= 1'b1;
        end else if (irq_mask_clr) begin
            ibit <= 1'b0;
        end
    end
    // sticky capture, pulses last one cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_seen <= 1'b0;
            presc_seen <= 1'b0;
        end else begin
            abort_seen <= abort_seen | mem_abort;
            presc_seen <= presc_seen | gate_out.wdog_presc_clr;
        end
    end
endmodule : lpmc_partner
